// ===== rtl/mfar_pkg.sv
/*
  Constants shared by the multi-I/O array read path of the serial flash:
  opcodes, address span, mode field code and dummy count coding.
  Assumes a 40 MHz system clock that oversamples the host serial clock.
*/
package mfar_pkg;

  // ----------------------------------------------------------------
  // Opcodes and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] MFAR_OP_DUAL = 8'h3b;
  localparam logic [7:0] MFAR_OP_QUAD = 8'h6b;
  localparam logic [7:0] MFAR_OP_XIP = 8'heb;
  localparam logic [7:0] MFAR_OP_XIP_ALIGNED = 8'he7;
  // Mode field value that keeps continuous read mode; any other value leaves it.
  localparam logic [7:0] MFAR_MODE_CONTINUE = 8'ha5;

  // ----------------------------------------------------------------
  // Array span and phase lengths
  // ----------------------------------------------------------------
  localparam int MFAR_ADDR_W = 24;
  localparam logic [23:0] MFAR_ADDR_TOP = 24'h1fffff;
  localparam logic [23:0] MFAR_ADDR_BOTTOM = 24'h000000;
  localparam logic [6:0] MFAR_OPCODE_CLKS = 7'h08;
  localparam logic [6:0] MFAR_SER_ADDR_CLKS = 7'h18;
  localparam logic [6:0] MFAR_QUAD_ADDR_CLKS = 7'h06;
  localparam logic [6:0] MFAR_DUMMY_BYTE_CLKS = 7'h08;
  localparam logic [6:0] MFAR_MODE_CLKS = 7'h02;
  localparam logic [2:0] MFAR_DC_MAX = 3'h4;

  typedef enum logic [2:0] {
    MFAR_IDLE = 3'b000,
    MFAR_OPC = 3'b001,
    MFAR_ADDR = 3'b010,
    MFAR_DUMMY = 3'b011,
    MFAR_DATA = 3'b100,
    MFAR_IGNORE = 3'b101
  } mfar_state_t;

  typedef enum logic [1:0] {
    MFAR_K_DUAL = 2'b00,
    MFAR_K_QUAD = 2'b01,
    MFAR_K_XIP = 2'b10
  } mfar_kind_t;

endpackage

// ===== rtl/mfar_read.sv
/*
  Multi-I/O array read path of a serial flash slave: dual output, quad
  output and quad-address execute-in-place reads with a wrapping counter.
  Assumes the host serial clock is at most an eighth of CLK_I, SPI mode 0,
  and that array data arrives one cycle after ARRAY_ADDR_O changes.
*/
`timescale 1ns/1ps

module mfar_read import mfar_pkg::*; (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic CSN_I,
  input wire logic SCK_I,
  input wire logic [3:0] IO_I,
  output logic [3:0] IO_O,
  output logic [3:0] IO_OE_O,
  input wire logic QUAD_ENABLE_BIT_I,
  input wire logic ALIGNED_ADDRESS_SELECT_I,
  input wire logic [2:0] DUMMY_COUNT_FIELD_I,
  output logic [23:0] ARRAY_ADDR_O,
  input wire logic [7:0] ARRAY_DATA_I,
  output logic XIP_ACTIVE_O,
  output logic BUSY_O
);

  typedef struct packed {
    logic [1:0] csn_s;
    logic [1:0] sck_s;
    logic [7:0] io_s;
    logic sck_last;
    mfar_state_t state;
    mfar_kind_t kind;
    logic [6:0] cnt;
    logic [7:0] shift;
    logic [23:0] addr;
    logic [7:0] mode;
    logic [7:0] dout;
    logic [1:0] slot;
    logic execute_in_place_read;
    logic aligned;
    logic [3:0] io;
    logic [3:0] oe;
    logic busy;
  } mfar_regs_t;

  mfar_regs_t r_q, r_d;
  logic cs_on, rise, fall;
  logic [3:0] pin;
  logic [6:0] dummy_clks;
  logic [7:0] op_byte;
  mfar_kind_t op_kind;
  logic op_ok;
  logic op_aligned;
  logic [3:0] slot_io;
  logic [3:0] slot_oe;
  logic [1:0] slot_next;
  logic slot_last;

  // ----------------------------------------------------------------
  // Opcode decode
  // ----------------------------------------------------------------
  // The byte is decoded as it will stand after the current rising edge,
  // so the phase can change on the edge that completes the opcode.
  always_comb begin
    op_byte = {r_q.shift[6:0], pin[0]};
    op_kind = MFAR_K_DUAL;
    op_ok = 1'b0;
    op_aligned = 1'b0;
    if (op_byte == MFAR_OP_DUAL) begin
      op_kind = MFAR_K_DUAL;
      op_ok = 1'b1;
    end else if (op_byte == MFAR_OP_QUAD) begin
      op_kind = MFAR_K_QUAD;
      op_ok = QUAD_ENABLE_BIT_I;
    end else if (op_byte == MFAR_OP_XIP) begin
      op_kind = MFAR_K_XIP;
      op_ok = 1'b1;
    end else if (op_byte == MFAR_OP_XIP_ALIGNED) begin
      op_kind = MFAR_K_XIP;
      op_ok = 1'b1;
      op_aligned = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Dummy phase length
  // ----------------------------------------------------------------
  always_comb begin
    // Codes above the top one clamp to the longest phase rather than run on.
    if (DUMMY_COUNT_FIELD_I > MFAR_DC_MAX) begin
      dummy_clks = 7'({MFAR_DC_MAX, 1'b0}) + MFAR_MODE_CLKS;
    end else begin
      dummy_clks = 7'({DUMMY_COUNT_FIELD_I, 1'b0}) + MFAR_MODE_CLKS;
    end
  end

  // ----------------------------------------------------------------
  // Output slot
  // ----------------------------------------------------------------
  // Dual bytes take four slots and quad bytes two; the slot counter picks
  // which bits of the held byte go out on the next falling edge.
  always_comb begin
    slot_io = 4'h0;
    slot_oe = 4'h0;
    slot_next = 2'h0;
    slot_last = 1'b0;
    case (r_q.kind)
      MFAR_K_DUAL: begin
        slot_oe = 4'h3;
        case (r_q.slot)
          2'h0: begin
            slot_io = {2'b00, r_q.dout[7:6]};
          end
          2'h1: begin
            slot_io = {2'b00, r_q.dout[5:4]};
          end
          2'h2: begin
            slot_io = {2'b00, r_q.dout[3:2]};
          end
          default: begin
            slot_io = {2'b00, r_q.dout[1:0]};
          end
        endcase
        slot_next = r_q.slot + 2'h1;
        slot_last = (r_q.slot == 2'h3);
      end
      default: begin
        // Quad output and the quad-address read share the four-line format.
        slot_oe = 4'hf;
        if (r_q.slot[0]) begin
          slot_io = r_q.dout[3:0];
        end else begin
          slot_io = r_q.dout[7:4];
        end
        slot_next = {1'b0, ~r_q.slot[0]};
        slot_last = r_q.slot[0];
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.csn_s = {r_q.csn_s[0], CSN_I};
    r_d.sck_s = {r_q.sck_s[0], SCK_I};
    r_d.io_s = {r_q.io_s[3:0], IO_I};
    r_d.sck_last = r_q.sck_s[1];
    cs_on = !r_q.csn_s[1];
    rise = r_q.sck_s[1] && !r_q.sck_last;
    fall = !r_q.sck_s[1] && r_q.sck_last;
    pin = r_q.io_s[7:4];
    r_d.busy = cs_on;
    if (!cs_on) begin
      // Release may come mid-byte; the output drivers let go at once.
      r_d.state = MFAR_IDLE;
      r_d.oe = 4'h0;
      r_d.cnt = 7'h00;
    end else begin
      case (r_q.state)
        MFAR_IDLE: begin
          r_d.cnt = 7'h00;
          if (r_q.execute_in_place_read) begin
            r_d.kind = MFAR_K_XIP;
            r_d.state = MFAR_ADDR;
          end else begin
            r_d.state = MFAR_OPC;
          end
        end
        MFAR_OPC: begin
          if (rise) begin
            r_d.shift = op_byte;
            r_d.cnt = r_q.cnt + 7'h01;
            if (r_q.cnt == MFAR_OPCODE_CLKS - 7'h01) begin
              r_d.cnt = 7'h00;
              r_d.kind = op_kind;
              r_d.aligned = op_aligned;
              // Refused opcodes wait out the frame with every pin released.
              if (op_ok) begin
                r_d.state = MFAR_ADDR;
              end else begin
                r_d.state = MFAR_IGNORE;
              end
            end
          end
        end
        MFAR_ADDR: begin
          if (rise) begin
            r_d.cnt = r_q.cnt + 7'h01;
            if (r_q.kind == MFAR_K_XIP) begin
              r_d.addr = {r_q.addr[19:0], pin[3], pin[2], pin[1], pin[0]};
              if (r_q.cnt == MFAR_QUAD_ADDR_CLKS - 7'h01) begin
                // Aligned when E7h, or EBh with the aligned select bit set.
                if (r_q.aligned || ALIGNED_ADDRESS_SELECT_I) begin
                  r_d.addr[1:0] = 2'b00;
                end
                r_d.cnt = 7'h00;
                r_d.mode = 8'h00;
                r_d.state = MFAR_DUMMY;
              end
            end else begin
              r_d.addr = {r_q.addr[22:0], pin[0]};
              if (r_q.cnt == MFAR_SER_ADDR_CLKS - 7'h01) begin
                r_d.cnt = 7'h00;
                r_d.state = MFAR_DUMMY;
                if (r_q.kind == MFAR_K_DUAL) begin
                  r_d.oe = 4'h0;
                end
              end
            end
          end
        end
        MFAR_DUMMY: begin
          r_d.slot = 2'h0;
          r_d.dout = ARRAY_DATA_I;
          if (rise) begin
            r_d.cnt = r_q.cnt + 7'h01;
            if (r_q.kind == MFAR_K_XIP) begin
              if (r_q.cnt < MFAR_MODE_CLKS) begin
                r_d.mode = {r_q.mode[3:0], pin};
              end
              if (r_q.cnt == dummy_clks - 7'h01) begin
                r_d.state = MFAR_DATA;
                r_d.execute_in_place_read = (r_d.mode == MFAR_MODE_CONTINUE);
              end
            end else if (r_q.cnt == MFAR_DUMMY_BYTE_CLKS - 7'h01) begin
              r_d.state = MFAR_DATA;
            end
          end
        end
        MFAR_DATA: begin
          // Pins change on the falling edge so the host samples on the rising one.
          if (fall) begin
            r_d.oe = slot_oe;
            r_d.io = slot_io;
            r_d.slot = slot_next;
            if (slot_last) begin
              r_d.dout = ARRAY_DATA_I;
            end
            if (r_q.slot == 2'h0) begin
              // Advance as the byte starts so the next one is ready in time.
              r_d.addr = (r_q.addr == MFAR_ADDR_TOP) ? MFAR_ADDR_BOTTOM : r_q.addr + 24'h000001;
            end
          end
        end
        default: begin
          r_d.oe = 4'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      r_q <= '{
        csn_s: 2'b11,
        sck_s: 2'b00,
        io_s: 8'h00,
        sck_last: 1'b0,
        state: MFAR_IDLE,
        kind: MFAR_K_DUAL,
        cnt: 7'h00,
        shift: 8'h00,
        addr: 24'h000000,
        mode: 8'h00,
        dout: 8'h00,
        slot: 2'h0,
        execute_in_place_read: 1'b0,
        aligned: 1'b0,
        io: 4'h0,
        oe: 4'h0,
        busy: 1'b0
      };
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Pin values and enables come straight from registers, so no glitch reaches the pads.
  assign IO_O = r_q.io;
  assign IO_OE_O = r_q.oe;
  assign ARRAY_ADDR_O = r_q.addr;
  assign XIP_ACTIVE_O = r_q.execute_in_place_read;
  assign BUSY_O = r_q.busy;

endmodule

// ===== testbench/mfar_read_checker.sv
/* Port assertions for the multi-I/O read path.
   Bound to mfar_read; sees only its ports. */
`timescale 1ns/1ps
module mfar_read_checker import mfar_pkg::*; (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic CSN_I,
  input wire logic QUAD_ENABLE_BIT_I,
  input wire logic [3:0] IO_OE_O,
  input wire logic [23:0] ARRAY_ADDR_O,
  input wire logic XIP_ACTIVE_O,
  input wire logic BUSY_O
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  a_oe_shape: assert property (IO_OE_O inside {4'h0, 4'h3, 4'hf})
    else $error("enable set out of shape");
  a_idle_quiet: assert property (CSN_I [*8] |-> IO_OE_O == 4'h0 && !BUSY_O)
    else $error("driving while deselected");
  a_release_float: assert property ($fell(BUSY_O) |-> ##[0:4] IO_OE_O == 4'h0)
    else $error("pins not floated");
  a_drive_busy: assert property ($rose(IO_OE_O != 4'h0) |-> BUSY_O)
    else $error("drive outside transfer");
  a_addr_step: assert property ($past(IO_OE_O) != 4'h0 && IO_OE_O != 4'h0 && $changed(ARRAY_ADDR_O)
    |-> ARRAY_ADDR_O == (($past(ARRAY_ADDR_O) + 24'h1) & MFAR_ADDR_TOP)) else $error("address step wrong");
  a_quad_gate: assert property (!QUAD_ENABLE_BIT_I && !XIP_ACTIVE_O |-> IO_OE_O != 4'hf)
    else $error("quad drive without enable");
  a_xip_set: assert property ($rose(XIP_ACTIVE_O) |-> BUSY_O)
    else $error("continuous mode set outside transfer");
  a_xip_hold: assert property (!BUSY_O && !$past(BUSY_O) |-> $stable(XIP_ACTIVE_O))
    else $error("continuous mode changed while idle");
  c_dual: cover property (IO_OE_O == 4'h3);
  c_quad: cover property (IO_OE_O == 4'hf);
  c_xip: cover property ($rose(XIP_ACTIVE_O));
endmodule

bind mfar_read mfar_read_checker CHK (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .CSN_I(CSN_I),
  .QUAD_ENABLE_BIT_I(QUAD_ENABLE_BIT_I), .IO_OE_O(IO_OE_O), .ARRAY_ADDR_O(ARRAY_ADDR_O),
  .XIP_ACTIVE_O(XIP_ACTIVE_O), .BUSY_O(BUSY_O));

// ===== testbench/mfar_host.sv
/* Host controller model for the serial flash pins, SPI mode 0.
   Assumes the bench resolves the shared data lines from the device enables. */
`timescale 1ns/1ps
module mfar_host (
  input wire logic clk_i,
  output logic csn_o,
  output logic sck_o,
  output logic [3:0] io_o,
  input wire logic [3:0] pin_i
);
  initial begin
    csn_o = 1'b1;
    sck_o = 1'b0;
    io_o = 4'h0;
  end
  // One 200 ns serial clock; the result is taken just before the next fall.
  task automatic tick(input logic [3:0] v, output logic [3:0] r);
    io_o <= v;
    repeat (4) @(posedge clk_i);
    sck_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    r = pin_i;
    sck_o <= 1'b0;
  endtask
  task automatic run(input logic [7:0] op, input bit skip, input bit qa, input logic [23:0] a,
    input logic [7:0] md, input int nd, input int nc, input int bpc, output logic [7:0] q[$]);
    logic [3:0] r;
    logic [7:0] b;
    q = {};
    b = 8'h0;
    csn_o <= 1'b0;
    @(posedge clk_i);
    if (!skip) for (int i = 7; i >= 0; i--) tick({3'h0, op[i]}, r);
    if (qa) for (int i = 5; i >= 0; i--) tick(a[4*i+:4], r);
    else for (int i = 23; i >= 0; i--) tick({3'h0, a[i]}, r);
    for (int i = 0; i < nd; i++) tick(i < 2 && qa ? md[7-4*i-:4] : 4'h0, r);
    // Released lines toggle so that a floating pin never reads as data.
    for (int i = 1; i <= nc; i++) begin
      tick(~io_o, r);
      b = bpc == 2 ? {b[5:0], r[1:0]} : {b[3:0], r};
      if (i * bpc % 8 == 0) q.push_back(b);
    end
    @(posedge clk_i);
    csn_o <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask
endmodule

// ===== testbench/mfar_read_tb_top.sv
/* Self-checking bench for the multi-I/O read path.
   Drives the pins through mfar_host and models the array as a function. */
`timescale 1ns/1ps
module mfar_read_tb_top import mfar_pkg::*; ;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic qe = 1'b1;
  logic al = 1'b0;
  int oe_cycles = 0;
  logic [2:0] dc = 3'h0;
  logic [7:0] arr = 8'h0;
  logic csn, sck, execute_in_place_read, busy;
  logic [3:0] hio, dio, doe, pin;
  logic [23:0] addr;
  int n_mismatch = 0;
  int checks = 0;
  int seed = 32'hbc5b8ba3;
  always #12.5 clk = ~clk;
  assign pin = (doe & dio) | (~doe & hio);
  mfar_read DUT (.CLK_I(clk), .RESETN_I(rst_n), .CSN_I(csn), .SCK_I(sck), .IO_I(pin), .IO_O(dio),
    .IO_OE_O(doe), .QUAD_ENABLE_BIT_I(qe), .ALIGNED_ADDRESS_SELECT_I(al), .DUMMY_COUNT_FIELD_I(dc),
    .ARRAY_ADDR_O(addr), .ARRAY_DATA_I(arr), .XIP_ACTIVE_O(execute_in_place_read), .BUSY_O(busy));
  mfar_host HOST (.clk_i(clk), .csn_o(csn), .sck_o(sck), .io_o(hio), .pin_i(pin));
  function automatic logic [7:0] fb(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ {3'h0, a[20:16]};
  endfunction
  function automatic logic [23:0] rnd();
    return 24'($random(seed)) & MFAR_ADDR_TOP;
  endfunction
  always @(posedge clk) begin
    arr <= fb(addr);
    if (doe != 4'h0) oe_cycles <= oe_cycles + 1;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] op, input bit skip, input bit qa, input logic [23:0] a,
    input logic [7:0] md, input int nd, input int nc, input int bpc, input bit fa);
    logic [7:0] q[$];
    HOST.run(op, skip, qa, a, md, nd, nc, bpc, q);
    if (fa) a[1:0] = 2'b00;
    foreach (q[i]) chk(q[i], fb((a + 24'(i)) & MFAR_ADDR_TOP));
    chk({busy, 3'h0, doe}, 8'h0);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Ten transfers of 22 to 56 serial clocks need near 70 us; allow far more.
  initial begin
    #1_500_000;
    n_mismatch++;
    close_out();
  end
  initial begin
    logic [7:0] q[$];
    int oe_before;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(MFAR_OP_DUAL, 0, 0, 24'h1ffffe, 8'h0, 8, 16, 2, 0);
    rd(MFAR_OP_DUAL, 0, 0, rnd(), 8'h0, 8, 3, 2, 0);
    $display("dual tests done");
    rd(MFAR_OP_QUAD, 0, 0, rnd(), 8'h0, 8, 9, 4, 0);
    qe <= 1'b0;
    oe_before = oe_cycles;
    HOST.run(MFAR_OP_QUAD, 0, 0, rnd(), 8'h0, 8, 4, 4, q);
    chk({7'h0, oe_cycles != oe_before}, 8'h0);
    qe <= 1'b1;
    $display("quad tests done");
    for (int k = 0; k <= 4; k++) begin
      dc <= k[2:0];
      al <= k == 2;
      rd(k[0] ? MFAR_OP_XIP_ALIGNED : MFAR_OP_XIP, 0, 1, rnd(), k == 4 ? MFAR_MODE_CONTINUE : 8'h0,
        2 * k + 2, 6, 4, k[0] || k == 2);
      chk({7'h0, execute_in_place_read}, {7'h0, k == 4});
    end
    rd(8'h0, 1, 1, rnd(), 8'h0, 10, 6, 4, 0);
    chk({7'h0, execute_in_place_read}, 8'h0);
    $display("execute in place tests done");
    close_out();
  end
endmodule
